// ### design/amst_params.svh
`ifndef AMST_PARAMS_SVH
`define AMST_PARAMS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AMST_ADDR_W         8
`define AMST_OFF_CTRL       8'h00
`define AMST_OFF_STATUS     8'h04
`define AMST_OFF_TIM_BASE   8'h10
`define AMST_OFF_TIM_LAST   8'h1c
// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define AMST_CTRL_SRC_LSB   0
`define AMST_CTRL_NDIV_LSB  2
`define AMST_CTRL_RST       4'h0
`define AMST_TIM_RST        26'h0842421
// ----------------------------------------------------------------
// Timing word layout (low bit of each field)
// ----------------------------------------------------------------
`define AMST_TIM_W          26
`define AMST_TIM_RD_SU_LSB  0
`define AMST_TIM_RD_STB_LSB 4
`define AMST_TIM_RD_HO_LSB  10
`define AMST_TIM_WR_SU_LSB  13
`define AMST_TIM_WR_STB_LSB 17
`define AMST_TIM_WR_HO_LSB  23
`define AMST_CNT_W          6
`endif

// ### design/amst_pkg.sv
package amst_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Access sequencer phases
	typedef enum logic [1:0] {
		AMST_IDLE,
		AMST_SETUP,
		AMST_STROBE,
		AMST_HOLD
	} amst_state_t;

	// Per chip-select-space timing, packed as in the timing register
	typedef struct packed {
		logic [2:0] write_hold_cycles;
		logic [5:0] write_strobe_cycles;
		logic [3:0] write_setup_cycles;
		logic [2:0] read_hold_cycles;
		logic [5:0] read_strobe_cycles;
		logic [3:0] read_setup_cycles;
	} amst_timing_t;

	// One access request from the core side
	typedef struct packed {
		logic        write;
		logic [1:0]  space;
		logic [19:0] word_addr;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} amst_req_t;

	// Divider select code to ratio: 0 -> 1, 1 -> 2, else 4
	function automatic logic [2:0] amst_ratio(input logic [1:0] sel);
		amst_ratio = (sel == 2'h0) ? 3'h1 : ((sel == 2'h1) ? 3'h2 : 3'h4);
	endfunction : amst_ratio

	// Zero counts act as one so that phases never collapse
	function automatic logic [5:0] amst_min1(input logic [5:0] v);
		amst_min1 = (v == 6'h00) ? 6'h01 : v;
	endfunction : amst_min1

endpackage : amst_pkg

// ### design/amst_top.sv
`timescale 1ns/10ps
`include "amst_params.svh"

// Function
// - interface clock from CPU, CPU/2, CPU/4
// - primary clock follows interface clock
// - divided clock is interface clock over N
// - divided clock has even duty cycle
// - ready synchronised, acted on at sampling edge
// - selects valid read-setup cycles before strobe
// - selects held read-hold cycles after strobe
// - selects and data valid write-setup cycles first
// - selects and data held write-hold cycles after
// - counts come from per-space timing registers
// - selects are enable, bytes, address, oe, data
// - control pins act as oe, read, write strobes
// - read strobe moves on primary rising edge
// - write strobe moves on primary rising edge
module amst_top
	import amst_pkg::*;
(
	input  wire logic                    i_mclk,
	input  wire logic                    i_resetn,
	input  wire logic [`AMST_ADDR_W-1:0] i_reg_addr,
	input  wire logic [31:0]             i_reg_wdata,
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	output logic      [31:0]             o_reg_rdata,
	input  wire logic                    i_acc_valid,
	input  wire amst_req_t               i_acc,
	output logic                         o_acc_busy,
	output logic                         o_acc_done,
	output logic      [31:0]             o_acc_rdata,
	output logic                         o_mem_clock_out_primary,
	output logic                         o_mem_clock_out_divided,
	input  wire logic                    i_async_ready_in,
	output logic      [3:0]              o_chip_enable_n,
	output logic      [3:0]              o_byte_enables_n,
	output logic      [19:0]             o_word_addr,
	output logic                         o_async_output_enable_n,
	output logic                         o_async_read_strobe_n,
	output logic                         o_async_write_strobe_n,
	input  wire logic [31:0]             i_mem_data_in,
	output logic      [31:0]             o_mem_data_out,
	output logic                         o_mem_data_oe
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0]        src_sel_r;     // Interface clock source select
	logic [1:0]        ndiv_sel_r;    // Divided clock ratio select
	amst_timing_t      tim_r [4];     // Timing per chip-select space
	logic [2:0]        half_cnt_r;    // Position within primary half period
	logic [2:0]        n_cnt_r;       // Primary half periods per divided half
	logic              prim_r;        // Primary memory clock
	logic              div_r;         // Divided memory clock
	logic              prim_tgl;      // Primary toggles at this edge
	logic              prim_rise;     // Primary rises at this edge
	logic [2:0]        src_ratio;     // Current source ratio
	logic [2:0]        n_ratio;       // Current divided ratio
	logic              rdy_s1_r;      // Ready synchroniser, first stage
	logic              rdy_s2_r;      // Ready synchroniser, second stage
	logic [31:0]       din_s1_r;      // Read data, first stage
	logic [31:0]       din_s2_r;      // Read data, second stage
	amst_state_t       state_r;       // Sequencer phase
	amst_state_t       state_nxt;
	logic [5:0]        cnt_r;         // Rising edges left in phase
	amst_req_t         req_r;         // Accepted request
	amst_timing_t      cur_r;         // Timing latched for this access
	logic              busy_r;
	logic              done_r;
	logic [31:0]       rdata_r;
	logic [31:0]       reg_rdata_r;
	logic [5:0]        su_eff;        // Effective setup count
	logic [5:0]        st_eff;        // Effective strobe count
	logic [5:0]        ho_eff;        // Effective hold count
	logic              tim_hit;       // Address falls in timing block
	logic [1:0]        tim_idx;

	assign src_ratio = amst_ratio(src_sel_r);
	assign n_ratio   = amst_ratio(ndiv_sel_r);
	assign tim_hit   = (i_reg_addr >= `AMST_OFF_TIM_BASE) && (i_reg_addr <= `AMST_OFF_TIM_LAST);
	assign tim_idx   = i_reg_addr[3:2];

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Control word; changing the source select mid-access changes phase lengths
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			{ndiv_sel_r, src_sel_r} <= `AMST_CTRL_RST;
		end
		else if (i_reg_wr && (i_reg_addr == `AMST_OFF_CTRL))
		begin
			src_sel_r  <= i_reg_wdata[`AMST_CTRL_SRC_LSB +: 2];
			ndiv_sel_r <= i_reg_wdata[`AMST_CTRL_NDIV_LSB +: 2];
		end
	end

	// Per-space timing words
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				tim_r[i] <= amst_timing_t'(`AMST_TIM_RST);
			end
		end
		else if (i_reg_wr && tim_hit)
		begin
			tim_r[tim_idx] <= amst_timing_t'(i_reg_wdata[`AMST_TIM_W-1:0]);
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	// Data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			reg_rdata_r <= 32'h0000_0000;
		end
		else if (!i_reg_rd)
		begin
			reg_rdata_r <= 32'h0000_0000;
		end
		else if (i_reg_addr == `AMST_OFF_CTRL)
		begin
			reg_rdata_r <= {28'h0000000, ndiv_sel_r, src_sel_r};
		end
		else if (i_reg_addr == `AMST_OFF_STATUS)
		begin
			reg_rdata_r <= {26'h0000000, div_r, prim_r, rdy_s2_r, state_r, busy_r};
		end
		else if (tim_hit)
		begin
			reg_rdata_r <= {6'h00, tim_r[tim_idx]};
		end
		else
		begin
			// Unmapped offsets read as zero
			reg_rdata_r <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Memory clocks
	// ----------------------------------------------------------------
	// The core clock runs at twice the CPU rate: one CPU half period per
	// edge, so every memory clock stays a plain flop output
	assign prim_tgl  = (half_cnt_r >= (src_ratio - 3'h1));
	assign prim_rise = prim_tgl && !prim_r;

	// Primary clock follows the selected source phases
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			half_cnt_r <= 3'h0;
			prim_r     <= 1'b0;
		end
		else if (prim_tgl)
		begin
			half_cnt_r <= 3'h0;
			prim_r     <= !prim_r;
		end
		else
		begin
			half_cnt_r <= half_cnt_r + 3'h1;
		end
	end

	// Divided clock toggles every N primary half periods: even duty
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			n_cnt_r <= 3'h0;
			div_r   <= 1'b0;
		end
		else if (prim_tgl && (n_cnt_r >= (n_ratio - 3'h1)))
		begin
			n_cnt_r <= 3'h0;
			div_r   <= !div_r;
		end
		else if (prim_tgl)
		begin
			n_cnt_r <= n_cnt_r + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Pin input synchronisers
	// ----------------------------------------------------------------
	// Ready and read data pass two flops before any use
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rdy_s1_r <= 1'b0;
			rdy_s2_r <= 1'b0;
			din_s1_r <= 32'h0000_0000;
			din_s2_r <= 32'h0000_0000;
		end
		else
		begin
			rdy_s1_r <= i_async_ready_in;
			rdy_s2_r <= rdy_s1_r;
			din_s1_r <= i_mem_data_in;
			din_s2_r <= din_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	// Effective counts for the access under way
	always_comb
	begin
		su_eff = amst_min1(req_r.write ? {2'h0, cur_r.write_setup_cycles}
			: {2'h0, cur_r.read_setup_cycles});
		st_eff = amst_min1(req_r.write ? cur_r.write_strobe_cycles : cur_r.read_strobe_cycles);
		ho_eff = amst_min1(req_r.write ? {3'h0, cur_r.write_hold_cycles}
			: {3'h0, cur_r.read_hold_cycles});
	end

	// Phase moves only on a primary rising edge
	always_comb
	begin
		state_nxt = state_r;
		if (prim_rise)
		begin
			case (state_r)
				AMST_IDLE:   if (busy_r && !done_r) state_nxt = AMST_SETUP;
				AMST_SETUP:  if (cnt_r == 6'h00) state_nxt = AMST_STROBE;
				AMST_STROBE: if ((cnt_r == 6'h00) && rdy_s2_r) state_nxt = AMST_HOLD;
				AMST_HOLD:   if (cnt_r == 6'h00) state_nxt = AMST_IDLE;
				default:     state_nxt = AMST_IDLE;
			endcase
		end
	end

	// Request acceptance; done pulses once as the selects drop
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			req_r  <= '0;
		end
		else
		begin
			done_r <= (state_r == AMST_HOLD) && (state_nxt == AMST_IDLE);
			if (!busy_r && i_acc_valid)
			begin
				busy_r <= 1'b1;
				req_r  <= i_acc;
			end
			else if (done_r)
			begin
				busy_r <= 1'b0;
			end
		end
	end

	// Phase, counter and pins
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_r                 <= AMST_IDLE;
			cnt_r                   <= 6'h00;
			cur_r                   <= '0;
			rdata_r                 <= 32'h0000_0000;
			o_chip_enable_n         <= 4'hf;
			o_async_read_strobe_n   <= 1'b1;
			o_async_write_strobe_n  <= 1'b1;
			o_async_output_enable_n <= 1'b1;
			o_byte_enables_n        <= 4'hf;
			o_word_addr             <= 20'h00000;
			o_mem_data_out          <= 32'h0000_0000;
			o_mem_data_oe           <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (prim_rise)
			begin
				case (state_r)
					AMST_IDLE:
					begin
						if (busy_r && !done_r)
						begin
							// Whole select group goes valid together
							cur_r                   <= tim_r[req_r.space];
							cnt_r                   <= amst_min1(req_r.write
								? {2'h0, tim_r[req_r.space].write_setup_cycles}
								: {2'h0, tim_r[req_r.space].read_setup_cycles}) - 6'h01;
							o_chip_enable_n         <= ~(4'h1 << req_r.space);
							o_byte_enables_n        <= ~req_r.byte_en;
							o_word_addr             <= req_r.word_addr;
							o_async_output_enable_n <= req_r.write;
							o_mem_data_out          <= req_r.wdata;
							o_mem_data_oe           <= req_r.write;
						end
					end
					AMST_SETUP:
					begin
						if (cnt_r == 6'h00)
						begin
							cnt_r                  <= st_eff - 6'h01;
							o_async_read_strobe_n  <= req_r.write;
							o_async_write_strobe_n <= !req_r.write;
						end
						else
						begin
							cnt_r <= cnt_r - 6'h01;
						end
					end
					AMST_STROBE:
					begin
						if ((cnt_r == 6'h00) && rdy_s2_r)
						begin
							// Strobe ends; data seen while it was low is kept
							cnt_r                  <= ho_eff - 6'h01;
							o_async_read_strobe_n  <= 1'b1;
							o_async_write_strobe_n <= 1'b1;
							if (!req_r.write)
							begin
								rdata_r <= din_s2_r;
							end
						end
						else if (cnt_r != 6'h00)
						begin
							cnt_r <= cnt_r - 6'h01;
						end
					end
					AMST_HOLD:
					begin
						if (cnt_r == 6'h00)
						begin
							o_chip_enable_n         <= 4'hf;
							o_byte_enables_n        <= 4'hf;
							o_async_output_enable_n <= 1'b1;
							o_mem_data_oe           <= 1'b0;
						end
						else
						begin
							cnt_r <= cnt_r - 6'h01;
						end
					end
					default:
					begin
						cnt_r <= 6'h00;
					end
				endcase
			end
		end
	end

	assign o_reg_rdata             = reg_rdata_r;
	assign o_acc_busy              = busy_r;
	assign o_acc_done              = done_r;
	assign o_acc_rdata             = rdata_r;
	assign o_mem_clock_out_primary = prim_r;
	assign o_mem_clock_out_divided = div_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking amst_cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);

	// Rising edges seen since the current phase began
	logic [7:0] ph_cnt_r;
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ph_cnt_r <= 8'h00;
		end
		else if (state_nxt != state_r)
		begin
			ph_cnt_r <= 8'h00;
		end
		else if (prim_rise)
		begin
			ph_cnt_r <= ph_cnt_r + 8'h01;
		end
	end

	a_src_ratio: assert property ($changed(prim_r) |-> $past(half_cnt_r) >= $past(src_ratio) - 3'h1)
		else $error("primary clock half period wrong");
	a_div_sync: assert property ($changed(div_r) |-> $changed(prim_r))
		else $error("divided clock moved off a primary edge");
	a_ready_wait: assert property ((state_r == AMST_STROBE) && prim_rise && (cnt_r == 6'h00) && !rdy_s2_r |=> (state_r == AMST_STROBE) && !(o_async_read_strobe_n && o_async_write_strobe_n))
		else $error("strobe ended without ready");
	a_rd_setup: assert property ($fell(o_async_read_strobe_n) |-> !o_chip_enable_n[req_r.space] && ($past(ph_cnt_r) == {2'h0, su_eff} - 8'h01))
		else $error("read setup count wrong");
	a_rd_hold: assert property ($rose(o_chip_enable_n[req_r.space]) && !req_r.write |-> $past(ph_cnt_r) == {2'h0, ho_eff} - 8'h01)
		else $error("read hold count wrong");
	a_wr_setup: assert property ($fell(o_async_write_strobe_n) |-> o_mem_data_oe && ($past(ph_cnt_r) == {2'h0, su_eff} - 8'h01))
		else $error("write setup count wrong");
	a_wr_hold: assert property ($rose(o_chip_enable_n[req_r.space]) && req_r.write |-> $past(o_mem_data_oe) && ($past(ph_cnt_r) == {2'h0, ho_eff} - 8'h01))
		else $error("write hold count wrong");
	a_sel_stable: assert property ((o_chip_enable_n != 4'hf) && $past(o_chip_enable_n != 4'hf) |-> $stable(o_word_addr) && $stable(o_byte_enables_n))
		else $error("select group moved during access");
	a_oe_read: assert property (!o_async_output_enable_n |-> !req_r.write && (o_chip_enable_n != 4'hf))
		else $error("output enable outside read access");
	a_rd_edge: assert property ($changed(o_async_read_strobe_n) |-> $rose(prim_r))
		else $error("read strobe moved off primary rise");
	a_wr_edge: assert property ($changed(o_async_write_strobe_n) |-> $rose(prim_r))
		else $error("write strobe moved off primary rise");
	a_idle_high: assert property ((state_r == AMST_IDLE) |-> o_async_read_strobe_n && o_async_write_strobe_n && (o_chip_enable_n == 4'hf))
		else $error("strobe or enable active while idle");

	c_read_done:  cover property (o_acc_done && !req_r.write);
	c_write_done: cover property (o_acc_done && req_r.write);
	c_ready_wait: cover property ((state_r == AMST_STROBE) && prim_rise && (cnt_r == 6'h00) && !rdy_s2_r);
	c_div_four:   cover property ((src_sel_r == 2'h2) && $rose(prim_r));

endmodule : amst_top

// ### dv/amst_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Async memory on the far side of the pins
// ----------------------------------------
module amst_mem_model (
	input  wire logic        i_mclk,
	input  wire logic [3:0]  i_ce_n,
	input  wire logic [3:0]  i_be_n,
	input  wire logic [19:0] i_addr,
	input  wire logic        i_oe_n,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wdata_oe,
	output logic      [31:0] o_rdata,
	output logic             o_ready
);
	logic [31:0] mem [0:15]; // Small store, low address bits only
	logic        pwr;        // Write strobe at the last edge
	logic        pst;        // Either strobe at the last edge
	int          wait_cyc;   // Ready low time, set by the bench
	int          wcnt;       // Ready low countdown

	initial
	begin
		for (int i = 0; i < 16; i++) mem[i] = 32'h0;
		pwr = 1'b1;
		pst = 1'b1;
		wait_cyc = 0;
		wcnt = 0;
		o_rdata = 32'h0;
	end

	// Write data taken at strobe rise, lane by lane
	always @(posedge i_mclk)
	begin
		pwr <= i_wr_n;
		if (i_wr_n && !pwr && i_wdata_oe && i_ce_n != 4'hf)
			for (int b = 0; b < 4; b++)
				if (!i_be_n[b]) mem[i_addr[3:0]][8*b +: 8] <= i_wdata[8*b +: 8];
	end

	// Ready dropped after strobe fall; the bench keeps the pulse long
	always @(posedge i_mclk)
	begin
		pst <= i_rd_n & i_wr_n;
		if (pst && !(i_rd_n & i_wr_n)) wcnt <= wait_cyc;
		else if (wcnt > 0) wcnt <= wcnt - 1;
	end
	assign o_ready = (wcnt == 0);

	// Drive data only when selected; otherwise a toggling pattern, never stale
	always @(posedge i_mclk)
		if (i_ce_n != 4'hf && !i_oe_n) o_rdata <= mem[i_addr[3:0]];
		else o_rdata <= ~o_rdata;
endmodule : amst_mem_model

// ### dv/amst_top_test.sv
`timescale 1ns/10ps
`include "amst_params.svh"
module amst_top_test;
	import amst_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        i_mclk, i_resetn, i_reg_wr, i_reg_rd, i_acc_valid;
	logic [7:0]  i_reg_addr;
	logic [31:0] i_reg_wdata, o_reg_rdata, o_acc_rdata, mdin, mdout, d;
	amst_req_t   i_acc;
	logic        o_acc_busy, o_acc_done, pclk, dclk, rdy, oe_n, rd_n, wr_n, doe;
	logic [3:0]  ce_n, be_n, ce0, be0;
	logic [19:0] waddr, ad0;
	logic        oe0, doe0, pp, pd, pst, pact;
	logic [31:0] do0;
	int          error_cnt, n_checks, cyc, t0, t1, t2, su, wd, ho;
	int          sel_err, edge_err, per_p, per_d, hi_d, tp, td, r, nn;
	wire         st  = rd_n & wr_n;    // Both strobes high
	wire         act = (ce_n != 4'hf); // Some space selected

	amst_top amst_top_i (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_acc_valid(i_acc_valid), .i_acc(i_acc),
		.o_acc_busy(o_acc_busy), .o_acc_done(o_acc_done), .o_acc_rdata(o_acc_rdata),
		.o_mem_clock_out_primary(pclk), .o_mem_clock_out_divided(dclk),
		.i_async_ready_in(rdy), .o_chip_enable_n(ce_n), .o_byte_enables_n(be_n),
		.o_word_addr(waddr), .o_async_output_enable_n(oe_n),
		.o_async_read_strobe_n(rd_n), .o_async_write_strobe_n(wr_n),
		.i_mem_data_in(mdin), .o_mem_data_out(mdout), .o_mem_data_oe(doe));

	amst_mem_model amst_mem_model_i (
		.i_mclk(i_mclk), .i_ce_n(ce_n), .i_be_n(be_n), .i_addr(waddr),
		.i_oe_n(oe_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_wdata(mdout),
		.i_wdata_oe(doe), .o_rdata(mdin), .o_ready(rdy));

	always #2 i_mclk = ~i_mclk;

	// ----------------------------------------
	// Pin monitor, sampled at the falling edge
	// ----------------------------------------
	// Phase lengths are counted in core cycles between pin events
	always @(negedge i_mclk)
	begin
		if (act && !pact)
		begin
			t0 = cyc; ce0 = ce_n; be0 = be_n; ad0 = waddr;
			oe0 = oe_n; doe0 = doe; do0 = mdout;
		end
		else if (act && (waddr !== ad0 || be_n !== be0 || ce_n !== ce0 || oe_n !== oe0
			|| (doe0 && mdout !== do0))) sel_err++;
		if (!st && pst)
		begin
			su = cyc - t0; t1 = cyc;
		end
		if (st && !pst)
		begin
			wd = cyc - t1; t2 = cyc;
		end
		if (!act && pact) ho = cyc - t2;
		// A strobe may only move when the primary clock has just risen
		if (st !== pst && !(pclk && !pp)) edge_err++;
		if (pclk && !pp)
		begin
			per_p = cyc - tp; tp = cyc;
		end
		if (dclk && !pd)
		begin
			per_d = cyc - td; td = cyc;
		end
		if (!dclk && pd) hi_d = cyc - td;
		pact = act; pst = st; pp = pclk; pd = dclk; cyc++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_mclk);
		i_reg_addr <= a; i_reg_wdata <= v; i_reg_wr <= 1'b1;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_mclk);
		i_reg_addr <= a; i_reg_rd <= 1'b1;
		@(posedge i_mclk);
		i_reg_rd <= 1'b0;
		@(posedge i_mclk);
		v = o_reg_rdata;
	endtask : reg_rd

	// One access; returns at the edge where busy drops, so calls run back to back
	task automatic acc(input logic w, input logic [1:0] sp, input logic [19:0] a,
		input logic [3:0] be, input logic [31:0] v);
		int n;
		@(posedge i_mclk);
		i_acc <= {w, sp, a, be, v}; i_acc_valid <= 1'b1;
		@(posedge i_mclk);
		i_acc_valid <= 1'b0;
		n = 0;
		while (o_acc_done !== 1'b1 && n < 3000)
		begin
			@(posedge i_mclk);
			n++;
		end
		chk("acc_done", 32'h1, {31'h0, o_acc_done});
		// Busy still stands at the edge that sees done
		chk("acc_busy", 32'h1, {31'h0, o_acc_busy});
	endtask : acc

	function automatic logic [31:0] tim(input int r_su, r_stb, r_ho, w_su, w_stb, w_ho);
		tim = (r_su << `AMST_TIM_RD_SU_LSB) | (r_stb << `AMST_TIM_RD_STB_LSB)
			| (r_ho << `AMST_TIM_RD_HO_LSB) | (w_su << `AMST_TIM_WR_SU_LSB)
			| (w_stb << `AMST_TIM_WR_STB_LSB) | (w_ho << `AMST_TIM_WR_HO_LSB);
	endfunction : tim

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// Watchdog well beyond the few thousand cycles the sequence needs
	initial
	begin
		#100000;
		error_cnt++;
		test_done;
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		i_mclk = 0; i_resetn = 0; i_reg_wr = 0; i_reg_rd = 0; i_acc_valid = 0;
		i_reg_addr = 8'h00; i_reg_wdata = 32'h0; i_acc = '0;
		error_cnt = 0; n_checks = 0; cyc = 0; sel_err = 0; edge_err = 0;
		pst = 1; pact = 0; pp = 0; pd = 0; tp = 0; td = 0; t0 = 0; t1 = 0; t2 = 0;
		repeat (20) @(posedge i_mclk);
		i_resetn <= 1'b1;
		chk("ce_idle", 32'hf, {28'h0, ce_n});
		chk("strobe_idle", 32'h3, {30'h0, rd_n, wr_n});
		reg_rd(`AMST_OFF_TIM_BASE, d);
		chk("tim0_reset", `AMST_TIM_RST, d);
		// Idle status: not busy, phase idle, ready seen high
		reg_rd(`AMST_OFF_STATUS, d);
		chk("status_idle", 32'h8, d & 32'hf);
		reg_rd(8'h08, d);
		chk("unmapped", 32'h0, d);
		reg_wr(8'h18, tim(3, 4, 2, 2, 3, 3));
		reg_rd(8'h18, d);
		chk("tim2", tim(3, 4, 2, 2, 3, 3), d);
		// Every source code and divider code
		for (int s = 0; s < 4; s++)
			for (int n = 0; n < 4; n++)
			begin
				reg_wr(`AMST_OFF_CTRL, {28'h0, n[1:0], s[1:0]});
				repeat (120) @(posedge i_mclk);
				r = (s == 0) ? 1 : ((s == 1) ? 2 : 4);
				nn = (n == 0) ? 1 : ((n == 1) ? 2 : 4);
				chk("prim_period", 2 * r, per_p);
				chk("div_period", 2 * r * nn, per_d);
				chk("div_high", r * nn, hi_d);
			end
		// Last selects written were both code 3
		reg_rd(`AMST_OFF_CTRL, d);
		chk("ctrl_back", 32'hf, d);
		// Space 2 write then read, E is two core cycles
		reg_wr(`AMST_OFF_CTRL, 32'h0);
		acc(1'b1, 2'h2, 20'h00005, 4'b0101, 32'hcafe1234);
		chk("wr_setup", 4, su);
		chk("wr_strobe", 6, wd);
		chk("wr_hold", 6, ho);
		chk("wr_ce", 32'hb, {28'h0, ce0});
		chk("wr_be", 32'ha, {28'h0, be0});
		chk("wr_addr", 32'h5, {12'h0, ad0});
		chk("wr_data", 32'hcafe1234, do0);
		chk("wr_oe", 32'h3, {30'h0, oe0, doe0});
		acc(1'b0, 2'h2, 20'h00005, 4'hf, 32'h0);
		chk("rd_setup", 6, su);
		chk("rd_strobe", 8, wd);
		chk("rd_hold", 4, ho);
		chk("rd_oe", 32'h0, {31'h0, oe0});
		chk("rd_data", 32'h00fe0034, o_acc_rdata);
		// Ready held low stretches the strobe
		amst_mem_model_i.wait_cyc = 12;
		acc(1'b0, 2'h0, 20'h00005, 4'hf, 32'h0);
		chk("ready_wait", 32'h1, {31'h0, (wd > 4 && wd < 24)});
		chk("ready_data", 32'h00fe0034, o_acc_rdata);
		amst_mem_model_i.wait_cyc = 0;
		// Slow source, E is eight core cycles
		reg_wr(`AMST_OFF_CTRL, 32'h2);
		acc(1'b1, 2'h0, 20'h00003, 4'hf, 32'h89abcdef);
		chk("slow_setup", 8, su);
		chk("slow_strobe", 16, wd);
		chk("slow_hold", 8, ho);
		acc(1'b0, 2'h0, 20'h00003, 4'hf, 32'h0);
		chk("slow_rd_setup", 8, su);
		chk("slow_rd_hold", 8, ho);
		chk("slow_data", 32'h89abcdef, o_acc_rdata);
		chk("select_stable", 0, sel_err);
		chk("strobe_edges", 0, edge_err);
		chk("ce_end", 32'hf, {28'h0, ce_n});
		test_done;
	end
endmodule : amst_top_test
